/* File: core/arc_defs.vh */
// register map, field positions and timing constants for the converter control block
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH
`define ARC_OFF_CSRB 8'h03
`define ARC_OFF_RLO 8'h04
`define ARC_OFF_RHI 8'h05
`define ARC_OFF_CSRA 8'h06
`define ARC_OFF_SEL 8'h07
`define ARC_OFF_IMASK 8'h08
`define ARC_OFF_ISTAT 8'h09
`define ARC_OFF_SAMPLE 8'h0A
`define ARC_BIT_EN 7
`define ARC_BIT_START 6
`define ARC_BIT_TRIG 5
`define ARC_BIT_DONE 4
`define ARC_BIT_IE 3
`define ARC_BIT_LEFT 5
`define ARC_BIT_REFHI 4
`define ARC_BIT_CHTOP 3
`define ARC_CYC_NORMAL 5'h0D
`define ARC_CYC_LONG 5'h19
`define ARC_RESET_BYTE 8'h00
`endif

/* File: core/arc_clk_div.v */
// converter clock tick generator from the system clock
`timescale 1ns/1ps
`default_nettype none
module arc_clk_div (
  input wire clk,
  input wire rst,
  input wire run,
  input wire [2:0] divider_sel,
  output reg tick_q
);
  reg [6:0] count_q;
  reg [6:0] limit;
  always @*
  begin
    case (divider_sel)
      3'h2: limit = 7'h03;
      3'h3: limit = 7'h07;
      3'h4: limit = 7'h0F;
      3'h5: limit = 7'h1F;
      3'h6: limit = 7'h3F;
      3'h7: limit = 7'h7F;
      default: limit = 7'h01; // 000 and 001 both divide by two [R5]
    endcase
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= 7'h00;
      tick_q <= 1'b0;
    end
    else if (!run)
    begin
      count_q <= 7'h00;
      tick_q <= 1'b0;
    end
    else if (count_q >= limit)
    begin
      count_q <= 7'h00;
      tick_q <= 1'b1; // [R5]
    end
    else
    begin
      count_q <= count_q + 7'h01;
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: core/arc_ctrl.v */
// converter control: status flags, result bytes, selection staging, apb slave
`timescale 1ns/1ps
`default_nettype none
`include "arc_defs.vh"
// Summary of operation
// (R1) done flag sets when a conversion ends and result bytes are updated
// (R2) interrupt requested only with done flag, enable and global enable all set; irq_q ignores them, set from istat and imask
// (R3) taking the interrupt vector clears the done flag
// (R4) writing one clears the done flag; zero leaves it
// (R5) three-bit divider gives 2,2,4,8,16,32,64,128
// (R6) right alignment: high byte holds bits 9:8, low byte bits 7:0
// (R7) left alignment: high byte holds bits 9:2, low byte bits 1:0 at 7:6
// (R8) reading low byte freezes both bytes until high byte read
// (R9) software reads low before high, or only high for 8-bit left results
// (R10) alignment change re-presents the stored result at once
// (R11) reference code decodes to supply, pin, 1.1V, reserved, 2.56V, 2.56V bypass
// (R12) reference and channel changes apply only when a conversion starts or the done flag sets
// (R13) conversion after a reference change lasts 25 converter clocks
// (R14) software should force a long conversion or discard first results
// (R15) normal conversion 13 cycles; first after enable 25 cycles
// (R16) channel top bit in register b sits above the five low channel bits
// (R17) unused result bits read zero; writes to result bytes ignored
module arc_ctrl (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire global_irq_enable,
  input wire vector_taken,
  input wire [9:0] sample_in,
  output reg conv_irq_q,
  output reg irq_q,
  output reg [5:0] active_channel_q,
  output reg [2:0] active_reference_q,
  output reg [2:0] reference_mode_q,
  output reg converting_q
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam REF_SUPPLY = 3'h0;
  localparam REF_PIN = 3'h1;
  localparam REF_INT11 = 3'h2;
  localparam REF_RSVD = 3'h3;
  localparam REF_INT256 = 3'h4;
  localparam REF_INT256_BYP = 3'h5;
  reg [1:0] state_q;
  reg [7:0] csra_q;
  reg [7:0] sel_q;
  reg [7:0] csrb_q;
  reg [9:0] result_q;
  reg [9:0] sync1_q;
  reg [9:0] sync2_q;
  reg frozen_q;
  reg first_q;
  reg ref_changed_q;
  reg [4:0] cyc_q;
  reg [4:0] cyc_len_q;
  reg [1:0] istat_q;
  reg [1:0] imask_q;
  wire tick;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire [7:0] addr = paddr[9:2];
  wire [7:0] wbyte = pwdata[7:0];
  // a tick left over from before a disable must not finish an aborted conversion
  wire done_evt = (state_q == ST_CONV) && csra_q[`ARC_BIT_EN] && tick &&
    (cyc_q == cyc_len_q - 5'h01);
  wire start_wr = wr && (addr == `ARC_OFF_CSRA) && wbyte[`ARC_BIT_START];
  wire en_now = (wr && (addr == `ARC_OFF_CSRA)) ? wbyte[`ARC_BIT_EN] : csra_q[`ARC_BIT_EN];
  wire [2:0] new_ref = {csrb_q[`ARC_BIT_REFHI], sel_q[7:6]};
  wire ref_write = wr && ((addr == `ARC_OFF_SEL) || (addr == `ARC_OFF_CSRB));

  function [2:0] ref_decode;
    input [2:0] code;
    begin
      case (code[1:0])
        2'h0: ref_decode = REF_SUPPLY;
        2'h1: ref_decode = REF_PIN;
        2'h2: ref_decode = code[2] ? REF_INT256 : REF_INT11;
        default: ref_decode = code[2] ? REF_INT256_BYP : REF_RSVD;
      endcase
    end
  endfunction

  function [7:0] result_byte;
    input [9:0] res;
    input left;
    input high;
    begin
      if (left)
        result_byte = high ? res[9:2] : {res[1:0], 6'h00}; // [R7] [R17]
      else
        result_byte = high ? {6'h00, res[9:8]} : res[7:0]; // [R6] [R17]
    end
  endfunction

  arc_clk_div u_div (
    .clk(clk),
    .rst(rst),
    .run(csra_q[`ARC_BIT_EN]),
    .divider_sel(csra_q[2:0]),
    .tick_q(tick)
  );

  // result input comes from the analog side, so synchronise it
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end
    else
    begin
      sync1_q <= sample_in;
      sync2_q <= sync1_q;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      csra_q <= `ARC_RESET_BYTE;
      sel_q <= `ARC_RESET_BYTE;
      csrb_q <= `ARC_RESET_BYTE;
      result_q <= 10'h000;
      frozen_q <= 1'b0;
      first_q <= 1'b1;
      ref_changed_q <= 1'b0;
      cyc_q <= 5'h00;
      cyc_len_q <= `ARC_CYC_NORMAL;
      istat_q <= 2'h0;
      imask_q <= 2'h0;
      active_channel_q <= 6'h00;
      active_reference_q <= 3'h0;
      reference_mode_q <= REF_SUPPLY;
    end
    else
    begin
      // start bit belongs to the sequencer, so writing zero to it does nothing
      if (wr && (addr == `ARC_OFF_CSRA))
        csra_q[`ARC_BIT_EN] <= wbyte[`ARC_BIT_EN];
      if (wr && (addr == `ARC_OFF_CSRA))
        csra_q[`ARC_BIT_TRIG] <= wbyte[`ARC_BIT_TRIG];
      if (wr && (addr == `ARC_OFF_CSRA))
        csra_q[3:0] <= wbyte[3:0];
      if (wr && (addr == `ARC_OFF_SEL))
        sel_q <= wbyte;
      if (wr && (addr == `ARC_OFF_CSRB))
        csrb_q <= {wbyte[7:6], 1'b0, wbyte[4:0]};
      if (wr && (addr == `ARC_OFF_IMASK))
        imask_q <= wbyte[1:0];
      if (ref_write && (ref_decode(new_ref) != ref_decode(
        (addr == `ARC_OFF_SEL) ? {csrb_q[`ARC_BIT_REFHI], wbyte[7:6]}
                               : {wbyte[`ARC_BIT_REFHI], sel_q[7:6]})))
        ref_changed_q <= 1'b1;
      if (!en_now)
        first_q <= 1'b1;
      // sets win over clears below
      if (done_evt)
        csra_q[`ARC_BIT_DONE] <= 1'b1; // [R1]
      else if (vector_taken)
        csra_q[`ARC_BIT_DONE] <= 1'b0; // [R3]
      else if (wr && (addr == `ARC_OFF_CSRA) && wbyte[`ARC_BIT_DONE])
        csra_q[`ARC_BIT_DONE] <= 1'b0; // [R4]
      if (wr && (addr == `ARC_OFF_ISTAT))
        istat_q <= (istat_q & ~wbyte[1:0]) | {frozen_q && done_evt, done_evt};
      else
        istat_q <= istat_q | {frozen_q && done_evt, done_evt};
      if (rd && (addr == `ARC_OFF_RLO))
        frozen_q <= 1'b1; // [R8]
      if (rd && (addr == `ARC_OFF_RHI))
        frozen_q <= 1'b0; // [R8]
      case (state_q)
        ST_IDLE:
        begin
          cyc_q <= 5'h00;
          if (start_wr && en_now)
          begin
            state_q <= ST_CONV;
            csra_q[`ARC_BIT_START] <= 1'b1;
            first_q <= 1'b0;
            ref_changed_q <= 1'b0;
            // long conversion after enable or reference change [R13] [R15]
            cyc_len_q <= (first_q || ref_changed_q) ? `ARC_CYC_LONG : `ARC_CYC_NORMAL;
            active_channel_q <= {csrb_q[`ARC_BIT_CHTOP], sel_q[4:0]}; // [R16]
            active_reference_q <= new_ref;
            reference_mode_q <= ref_decode(new_ref); // [R11]
          end
          else
            csra_q[`ARC_BIT_START] <= 1'b0;
        end
        ST_CONV:
        begin
          if (!csra_q[`ARC_BIT_EN])
          begin
            state_q <= ST_IDLE;
            csra_q[`ARC_BIT_START] <= 1'b0;
          end
          else if (done_evt)
          begin
            state_q <= ST_IDLE;
            csra_q[`ARC_BIT_START] <= 1'b0;
            if (!frozen_q && !(rd && (addr == `ARC_OFF_RLO)))
              result_q <= sync2_q; // [R8]
            // staged selections take effect as the flag sets [R12] [R16]
            active_channel_q <= {csrb_q[`ARC_BIT_CHTOP], sel_q[4:0]};
            active_reference_q <= new_ref;
            reference_mode_q <= ref_decode(new_ref); // [R11]
          end
          else if (tick)
            cyc_q <= cyc_q + 5'h01;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // apb answers with zero wait states; registers sit at byte address offset*4
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      conv_irq_q <= 1'b0;
      irq_q <= 1'b0;
      converting_q <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (addr)
          `ARC_OFF_CSRA: prdata <= {24'h00_0000, csra_q};
          `ARC_OFF_SEL: prdata <= {24'h00_0000, sel_q};
          `ARC_OFF_CSRB: prdata <= {24'h00_0000, csrb_q};
          // alignment taken live from the select register [R10]
          `ARC_OFF_RLO: prdata <= {24'h00_0000, result_byte(result_q, sel_q[`ARC_BIT_LEFT], 1'b0)};
          `ARC_OFF_RHI: prdata <= {24'h00_0000, result_byte(result_q, sel_q[`ARC_BIT_LEFT], 1'b1)};
          `ARC_OFF_IMASK: prdata <= {30'h0000_0000, imask_q};
          `ARC_OFF_ISTAT: prdata <= {30'h0000_0000, istat_q};
          `ARC_OFF_SAMPLE: prdata <= {22'h00_0000, result_q};
          default: prdata <= 32'h0000_0000;
        endcase
        case (addr)
          `ARC_OFF_CSRA, `ARC_OFF_SEL, `ARC_OFF_CSRB, `ARC_OFF_RLO, `ARC_OFF_RHI,
          `ARC_OFF_IMASK, `ARC_OFF_ISTAT, `ARC_OFF_SAMPLE: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
      else if (psel && !penable)
        pslverr <= !((addr == `ARC_OFF_CSRA) || (addr == `ARC_OFF_SEL) ||
          (addr == `ARC_OFF_CSRB) || (addr == `ARC_OFF_IMASK) ||
          (addr == `ARC_OFF_ISTAT) || (addr == `ARC_OFF_RLO) || (addr == `ARC_OFF_RHI));
      conv_irq_q <= csra_q[`ARC_BIT_DONE] && csra_q[`ARC_BIT_IE] && global_irq_enable; // [R2]
      irq_q <= |(istat_q & imask_q);
      converting_q <= (state_q == ST_CONV);
    end
  end
endmodule
`default_nettype wire

/* File: dv/arc_ctrl_props.sv */
// port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic vector_taken,
  input wire logic conv_irq_q,
  input wire logic converting_q,
  input wire logic [5:0] active_channel_q,
  input wire logic [2:0] active_reference_q,
  input wire logic [2:0] reference_mode_q
);
  logic [11:0] busy_cnt_q;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      busy_cnt_q <= 12'h000;
    else if (converting_q)
      busy_cnt_q <= busy_cnt_q + 12'h001;
    else
      busy_cnt_q <= 12'h000;
  end
  function automatic logic [2:0] ref_mode(input logic [2:0] c);
    return (c[1] == 1'b0) ? {2'h0, c[0]} : (c[2] ? {2'h2, c[0]} : {1'b0, c[1:0]});
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence apb_setup;
    psel && !penable;
  endsequence
  apb_answer_a: assert property (apb_setup |=> pready)
    else $error("setup not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  irq_gate_a: assert property (!global_irq_enable |=> !conv_irq_q)
    else $error("irq without global enable");
  vector_clear_a: assert property (vector_taken && !converting_q |=> ##1 !conv_irq_q)
    else $error("irq stays after vector");
  ref_decode_a: assert property (1'b1 |-> ##[0:1] (reference_mode_q == ref_mode(active_reference_q)))
    else $error("reference decode wrong");
  sel_defer_a: assert property (($changed(active_reference_q) || $changed(active_channel_q))
    |-> ##[0:2] !converting_q)
    else $error("selection applied mid conversion");
  conv_len_a: assert property ($fell(converting_q) |-> busy_cnt_q >= 12'h018)
    else $error("conversion too short");
  conv_max_a: assert property (busy_cnt_q <= 12'hC8A)
    else $error("conversion too long");
endmodule
bind arc_ctrl arc_ctrl_props u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
  .vector_taken(vector_taken), .conv_irq_q(conv_irq_q), .converting_q(converting_q),
  .active_channel_q(active_channel_q), .active_reference_q(active_reference_q),
  .reference_mode_q(reference_mode_q));
`default_nettype wire

/* File: dv/tb_arc_ctrl.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "arc_defs.vh"
module tb_arc_ctrl;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic gie = 1'b0, vt = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
  logic [9:0] smp = 10'h000, old;
  logic [16:0] n;
  logic [2:0] cc;
  logic [8:0] pr;
  logic [5:0] ch;
  wire [31:0] prdata;
  wire pready, pslverr, cirq, irq, busy;
  wire [5:0] ach;
  wire [2:0] reference_pin, rmode;
  logic [16:0] q[$];
  int failures = 0, n_tests = 0, len, f;
  int blen = 0;
  always #25 clk = ~clk;
  arc_ctrl dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(gie), .vector_taken(vt), .sample_in(smp), .conv_irq_q(cirq),
    .irq_q(irq), .active_channel_q(ach), .active_reference_q(reference_pin),
    .reference_mode_q(rmode), .converting_q(busy));
  function automatic logic [2:0] dec(input logic [2:0] c);
    return (c[1] == 1'b0) ? {2'h0, c[0]} : (c[2] ? {2'h2, c[0]} : {1'b0, c[1:0]});
  endfunction
  task check(input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task complete_run;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // offsets are word indices, so the byte address is four times the offset
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h00_0000, a, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input logic er);
    q.push_back({er, m, e});
    bus(1'b0, a, 8'h00);
  endtask
  // a wait ends once busy reaches lv; len is the busy span just finished
  task wbusy(input logic lv);
    while (busy !== lv)
      @(posedge clk);
    len = blen;
  endtask
  always @(posedge clk)
    blen <= busy ? blen + 1 : 0;
  always @(posedge clk)
    if (psel && penable && pready && !pwrite)
    begin
      n = q.pop_front();
      check({pslverr, prdata & {24'h00_0000, n[15:8]}}, {n[16], 24'h00_0000, n[7:0]});
    end
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial
  begin
    void'($urandom(32'h2522_8302));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`ARC_OFF_SEL, 8'hFF, 8'h00, 1'b0);
    rd(8'h30, 8'h00, 8'h00, 1'b1);
    bus(1'b1, `ARC_OFF_RLO, 8'hFF);
    rd(`ARC_OFF_RLO, 8'hFF, 8'h00, 1'b0);
    rd(`ARC_OFF_RHI, 8'hFF, 8'h00, 1'b0);
    for (int d = 0; d < 8; d++)
    begin
      smp <= 10'($urandom);
      bus(1'b1, `ARC_OFF_CSRA, {5'h19, 3'(d)});
      wbusy(1'b1);
      wbusy(1'b0);
      f = (d < 2) ? 2 : 1 << d;
      check(len >= ((d ? 13 : 25) - 1) * f + 1 && len <= (d ? 13 : 25) * f + 1, 1);
      rd(`ARC_OFF_CSRA, 8'h10, 8'h10, 1'b0);
      rd(`ARC_OFF_RLO, 8'hFF, smp[7:0], 1'b0);
      rd(`ARC_OFF_RHI, 8'hFF, {6'h00, smp[9:8]}, 1'b0);
    end
    gie <= 1'b1;
    repeat (2) @(posedge clk);
    check(cirq, 1);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    check(cirq, 0);
    gie <= 1'b1;
    vt <= 1'b1;
    @(posedge clk);
    vt <= 1'b0;
    repeat (2) @(posedge clk);
    check(cirq, 0);
    rd(`ARC_OFF_CSRA, 8'h10, 8'h00, 1'b0);
    check(irq, 0);
    bus(1'b1, `ARC_OFF_IMASK, 8'h01);
    repeat (2) @(posedge clk);
    check(irq, 1);
    bus(1'b1, `ARC_OFF_ISTAT, 8'h01);
    repeat (2) @(posedge clk);
    check(irq, 0);
    bus(1'b1, `ARC_OFF_CSRA, 8'hC8);
    wbusy(1'b1);
    wbusy(1'b0);
    bus(1'b1, `ARC_OFF_CSRA, 8'h88);
    rd(`ARC_OFF_CSRA, 8'h10, 8'h10, 1'b0);
    bus(1'b1, `ARC_OFF_CSRA, 8'h98);
    rd(`ARC_OFF_CSRA, 8'h10, 8'h00, 1'b0);
    bus(1'b1, `ARC_OFF_SEL, 8'h20);
    rd(`ARC_OFF_RLO, 8'hFF, {smp[1:0], 6'h00}, 1'b0);
    rd(`ARC_OFF_RHI, 8'hFF, smp[9:2], 1'b0);
    old = smp;
    smp <= 10'($urandom);
    bus(1'b1, `ARC_OFF_CSRA, 8'hC8);
    wbusy(1'b1);
    // alignment flips while the converter is still busy
    bus(1'b1, `ARC_OFF_SEL, 8'h00);
    rd(`ARC_OFF_RLO, 8'hFF, old[7:0], 1'b0);
    rd(`ARC_OFF_RHI, 8'hFF, {6'h00, old[9:8]}, 1'b0);
    wbusy(1'b0);
    rd(`ARC_OFF_RLO, 8'hFF, smp[7:0], 1'b0);
    old = smp;
    smp <= 10'($urandom);
    bus(1'b1, `ARC_OFF_CSRA, 8'hC8);
    wbusy(1'b1);
    wbusy(1'b0);
    rd(`ARC_OFF_RHI, 8'hFF, {6'h00, old[9:8]}, 1'b0);
    rd(`ARC_OFF_RLO, 8'hFF, old[7:0], 1'b0);
    rd(`ARC_OFF_ISTAT, 8'h02, 8'h02, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      cc = 3'(c);
      ch = 6'($urandom);
      bus(1'b1, `ARC_OFF_CSRA, 8'hC8);
      wbusy(1'b1);
      pr = {reference_pin, ach};
      bus(1'b1, `ARC_OFF_SEL, {cc[1:0], 1'b0, ch[4:0]});
      bus(1'b1, `ARC_OFF_CSRB, {3'h0, cc[2], ch[5], 3'h0});
      check({reference_pin, ach}, pr);
      wbusy(1'b0);
      // codes 0 and 0 match, so only from the third pass is the reference new
      check(len >= (c > 1 ? 49 : 25) && len <= (c > 1 ? 50 : 26), 1);
      repeat (2) @(posedge clk);
      check({reference_pin, ach, rmode}, {cc, ch, dec(cc)});
    end
    // switching off and on again forces a long conversion
    bus(1'b1, `ARC_OFF_CSRA, 8'h08);
    bus(1'b1, `ARC_OFF_CSRA, 8'hC8);
    wbusy(1'b1);
    wbusy(1'b0);
    check(len >= 49 && len <= 51, 1);
    complete_run();
  end
endmodule
`default_nettype wire
